/* File: bench/pifb_bank_tb.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// bench for the flag bank: register port and event sources
module pifb_bank_tb;
   import pifb_pkg::*;

   logic          ref_clk;     // core clock
   logic          resetn;      // async reset
   pifb_req_t     reg_req;     // register port request
   logic    [7:0] reg_rdata;   // read data
   pifb_events_t  src_evt;     // strobes from the model
   logic          periph_irq;  // peripheral request
   logic          core_irq;    // core request
   logic          bank_irq;    // bank interrupt
   int            mismatches;  // failed comparisons
   int            comparisons; // all comparisons
   int            cycles;      // run length for the timeout

   // index order: core ctrl, enables one-four, requests one-four
   localparam logic [3:0] IDX [0:8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
                                        4'h5, 4'h6, 4'h7, 4'h8};
   localparam logic [7:0] MSK [0:8] = '{8'hFF, 8'hFF, 8'hF9, 8'h3A, 8'h03,
                                        8'hFF, 8'hF9, 8'h3A, 8'h03};

   pifb_bank #(.LARGE_VARIANT(1'b1)) pifb_bank_inst (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .reg_req    (reg_req),
      .reg_rdata  (reg_rdata),
      .src_evt    (src_evt),
      .periph_irq (periph_irq),
      .core_irq   (core_irq),
      .bank_irq   (bank_irq)
   );

   pifb_src_model pifb_src_model_inst (
      .ref_clk (ref_clk),
      .src_evt (src_evt)
   );

   //////////////////////////////////////////////////////////////////////////
   // clock, time-zero values and timeout
   initial begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      reg_req = '0;
      mismatches = 0;
      comparisons = 0;
      cycles = 0;
   end
   always #5 ref_clk = ~ref_clk;

   // the whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches = mismatches + 1;
         results();
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("[ERR] %0t %s: seen %h expected %h", $time, m, seen, exp);
      end
   endtask

   // one-cycle write strobe, effect visible after return
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      reg_req <= '0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      reg_req <= '0;
      #1;
      d = reg_rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string m);
      logic [7:0] v;
      rd(a, v);
      chk(v, exp, m);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      for (int i = 0; i < 11; i++) begin
         rd_chk(4'(i), 8'h00, "reset value");
      end
      rd_chk(4'hD, 8'h00, "unmapped read");
      $display("test reset values done");
   endtask

   // every implemented bit holds, every hole reads zero
   task automatic t_layout();
      for (int i = 0; i < 9; i++) begin
         wr(IDX[i], 8'hFF);
         rd_chk(IDX[i], MSK[i], "ones pattern");
         wr(IDX[i], 8'h00);
         rd_chk(IDX[i], 8'h00, "zeros pattern");
      end
      wr(4'hC, 8'hFF);
      rd_chk(4'hC, 8'h00, "unmapped write");
      wr(4'h9, 8'h03);
      $display("test register layout done");
   endtask

   // hardware sets flags while every enable is off
   task automatic t_events();
      pifb_src_model_inst.fire('{grp_one: 8'hFF, grp_two: 8'hFF, grp_three: 8'hFF,
                                 grp_four: 8'hFF, core: 3'h7});
      chk({6'h00, periph_irq, core_irq}, 8'h00, "no request when disabled");
      rd_chk(4'h5, 8'hFF, "group one flags");
      rd_chk(4'h6, 8'hF9, "group two flags");
      rd_chk(4'h7, 8'h3A, "group three flags");
      rd_chk(4'h8, 8'h03, "group four flags");
      rd_chk(4'h0, 8'h07, "core flags");
      for (int i = 0; i < 9; i++) begin
         wr(IDX[i], 8'h00);
      end
      rd_chk(4'h8, 8'h00, "flags cleared by software");
      $display("test hardware set done");
   endtask

   // request path, master enables and the bank interrupt
   task automatic t_gating();
      wr(4'h2, 8'h80);
      wr(4'h0, 8'hC0);
      chk({7'h00, periph_irq}, 8'h00, "idle request");
      pifb_src_model_inst.fire('{grp_one: 8'h00, grp_two: 8'h80, grp_three: 8'h00,
                                 grp_four: 8'h00, core: 3'h0});
      chk({6'h00, periph_irq, core_irq}, 8'h03, "request raised");
      wr(4'h0, 8'h80);
      chk({7'h00, periph_irq}, 8'h00, "master enable off");
      wr(4'h0, 8'h40);
      chk({7'h00, periph_irq}, 8'h00, "global enable off");
      wr(4'h0, 8'hC0);
      chk({7'h00, periph_irq}, 8'h01, "request back");
      rd_chk(4'h9, 8'h03, "status rises");
      chk({7'h00, bank_irq}, 8'h00, "masked bank interrupt");
      wr(4'hA, 8'h01);
      chk({7'h00, bank_irq}, 8'h01, "unmasked bank interrupt");
      wr(4'h9, 8'h03);
      chk({7'h00, bank_irq}, 8'h00, "status cleared");
      wr(4'h6, 8'h00);
      chk({7'h00, periph_irq}, 8'h00, "flag cleared");
      wr(4'hA, 8'h00);
      wr(4'h0, 8'h00);
      $display("test request gating done");
   endtask

   // a same-edge clear must not lose the event
   task automatic t_setwins();
      fork
         wr(4'h6, 8'h00);
         pifb_src_model_inst.fire('{grp_one: 8'h00, grp_two: 8'h40, grp_three: 8'h00,
                                    grp_four: 8'h00, core: 3'h0});
      join
      rd_chk(4'h6, 8'h40, "set wins over write");
      wr(4'h6, 8'h00);
      $display("test set priority done");
   endtask

   // core-level timer flag drives only the core request
   task automatic t_core();
      pifb_src_model_inst.fire('{grp_one: 8'h00, grp_two: 8'h00, grp_three: 8'h00,
                                 grp_four: 8'h00, core: 3'h4});
      rd_chk(4'h0, 8'h04, "timer zero flag");
      chk({7'h00, core_irq}, 8'h00, "core request disabled");
      wr(4'h0, 8'hA4);
      chk({6'h00, periph_irq, core_irq}, 8'h01, "core request alone");
      $display("test core flags done");
   endtask

   // every group and the two remaining core sources reach a request line
   task automatic t_paths();
      pifb_events_t e;
      wr(4'h0, 8'hC0);
      for (int i = 1; i < 5; i++) begin
         wr(IDX[i], 8'hFF);
         e = '0;
         e[42-8*i -: 8] = MSK[i];
         pifb_src_model_inst.fire(e);
         chk({7'h00, periph_irq}, 8'h01, "group request");
         wr(IDX[i+4], 8'h00);
         chk({7'h00, periph_irq}, 8'h00, "group request cleared");
         wr(IDX[i], 8'h00);
      end
      wr(4'h9, 8'h03);
      wr(4'hA, 8'h02);
      wr(4'h0, 8'h98);
      for (int j = 0; j < 2; j++) begin
         e = '0;
         e.core[j] = 1'b1;
         pifb_src_model_inst.fire(e);
         chk({7'h00, core_irq}, 8'h01, "core source request");
         wr(4'h0, 8'h98);
         chk({7'h00, core_irq}, 8'h00, "core source cleared");
      end
      chk({7'h00, bank_irq}, 8'h01, "core rise in status");
      wr(4'h9, 8'h02);
      chk({7'h00, bank_irq}, 8'h00, "core rise cleared");
      wr(4'hA, 8'h00);
      wr(4'h0, 8'h00);
      $display("test request paths done");
   endtask

   // reset in mid-run returns everything to zero
   task automatic t_rerst();
      wr(4'h3, 8'h3A);
      rd_chk(4'h3, 8'h3A, "written before reset");
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      #1;
      chk({6'h00, periph_irq, core_irq}, 8'h00, "outputs after reset");
      for (int i = 0; i < 9; i++) begin
         rd_chk(IDX[i], 8'h00, "cleared by reset");
      end
      $display("test mid-run reset done");
   endtask

   //////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      t_reset();
      t_layout();
      t_events();
      t_gating();
      t_setwins();
      t_core();
      t_paths();
      t_rerst();
      results();
   end
endmodule

/* File: bench/pifb_src_model.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// event source model: peripherals that raise one-cycle set strobes
module pifb_src_model (
   // clock
   input  wire logic             ref_clk,
   // strobes toward the bank
   output pifb_pkg::pifb_events_t src_evt
);
   import pifb_pkg::*;

   // quiet until a source fires
   initial begin
      src_evt = '0;
   end

   // one strobe per event; collision and transfer end are single pulses
   // so a stuck source cannot mask a software clear
   task automatic fire(input pifb_events_t e);
      @(posedge ref_clk);
      src_evt <= e;
      @(posedge ref_clk);
      src_evt <= '0;
      #1;
   endtask
endmodule

/* File: rtl/pifb_bank.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// R1: no peripheral request without peripheral master enable
// R2: flags set by hardware regardless of enables
// R3: software clears stale flag before enabling
// R4: second enable register bit layout fixed
// R5: implemented bits read/write, reset to zero
// R6: unimplemented bits read as zero
// R7: third enable register bit layout fixed
// R8: second request flags mirror second enable
// R9: serial two collision sets fourth request bit1
// R10: serial two event sets fourth request bit0
// R11: core control register field order fixed
// R12: first enable/request register layout fixed
// R13: third request, fourth enable layouts fixed
// R14: large-variant registers removed by parameter
// R15: request when flag, enable, master enables set
// R16: hardware set beats same-cycle software write
module pifb_bank #(
   parameter bit LARGE_VARIANT = 1'b1   // keeps groups three, four, capture two
) (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 resetn,
   // register port
   input  wire pifb_pkg::pifb_req_t  reg_req,
   output logic                [7:0] reg_rdata,
   // source events, one-cycle strobes from core-clock logic
   input  wire pifb_pkg::pifb_events_t src_evt,
   // request lines to the core
   output logic                      periph_irq,
   output logic                      core_irq,
   // bank interrupt
   output logic                      bank_irq
);
   import pifb_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // build-time masks

   // group two bit 0 and groups three/four vanish in the small variant
   localparam logic [7:0] MASK_TWO   = LARGE_VARIANT ? PIFB_MASK_TWO_LARGE
                                                     : PIFB_MASK_TWO_SMALL;   // R14
   localparam logic [7:0] MASK_THREE = LARGE_VARIANT ? PIFB_MASK_THREE : 8'h00; // R14
   localparam logic [7:0] MASK_FOUR  = LARGE_VARIANT ? PIFB_MASK_FOUR : 8'h00;  // R14

   //////////////////////////////////////////////////////////////////////////
   // decode

   logic        wr_core;    // write to core control
   logic        wr_en1;     // write to enable group one
   logic        wr_en2;     // write to enable group two
   logic        wr_en3;     // write to enable group three
   logic        wr_en4;     // write to enable group four
   logic        wr_req1;    // write to request group one
   logic        wr_req2;    // write to request group two
   logic        wr_req3;    // write to request group three
   logic        wr_req4;    // write to request group four
   logic        wr_stat;    // write-one-to-clear on bank status
   logic        wr_mask;    // write to bank mask

   // one strobe per register, gated by the write strobe
   always_comb begin
      wr_core = reg_req.wr && (reg_req.addr == PIFB_OFS_CORE_CTRL);
      wr_en1  = reg_req.wr && (reg_req.addr == PIFB_OFS_EN_ONE);
      wr_en2  = reg_req.wr && (reg_req.addr == PIFB_OFS_EN_TWO);
      wr_en3  = reg_req.wr && (reg_req.addr == PIFB_OFS_EN_THREE);
      wr_en4  = reg_req.wr && (reg_req.addr == PIFB_OFS_EN_FOUR);
      wr_req1 = reg_req.wr && (reg_req.addr == PIFB_OFS_REQ_ONE);
      wr_req2 = reg_req.wr && (reg_req.addr == PIFB_OFS_REQ_TWO);
      wr_req3 = reg_req.wr && (reg_req.addr == PIFB_OFS_REQ_THREE);
      wr_req4 = reg_req.wr && (reg_req.addr == PIFB_OFS_REQ_FOUR);
      wr_stat = reg_req.wr && (reg_req.addr == PIFB_OFS_IRQ_STAT);
      wr_mask = reg_req.wr && (reg_req.addr == PIFB_OFS_IRQ_MASK);
   end

   //////////////////////////////////////////////////////////////////////////
   // enable registers

   logic [7:0] en_one_r;     // timer one gate .. timer one overflow
   logic [7:0] en_two_r;     // osc fail .. capture two
   logic [7:0] en_three_r;   // capture four/three, timer six/four
   logic [7:0] en_four_r;    // serial two collision / event

   // plain read/write enables, masked to implemented bits
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         en_one_r   <= PIFB_RST_VAL;   // R5
         en_two_r   <= PIFB_RST_VAL;
         en_three_r <= PIFB_RST_VAL;
         en_four_r  <= PIFB_RST_VAL;
      end else begin
         if (wr_en1) begin
            en_one_r <= reg_req.wdata & PIFB_MASK_ONE;   // R12
         end
         if (wr_en2) begin
            en_two_r <= reg_req.wdata & MASK_TWO;   // R4 R6
         end
         if (wr_en3) begin
            en_three_r <= reg_req.wdata & MASK_THREE;   // R7 R6
         end
         if (wr_en4) begin
            en_four_r <= reg_req.wdata & MASK_FOUR;   // R13 R6
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // request flag registers, one generate entry per group

   logic [3:0][7:0] req_r;     // request groups one..four
   logic [3:0][7:0] req_set;   // hardware set strobes per group
   logic [3:0]      req_wr;    // software write per group

   // route event strobes onto flag positions of each group
   always_comb begin
      req_set[0] = src_evt.grp_one;     // R12
      req_set[1] = src_evt.grp_two;     // R8
      req_set[2] = src_evt.grp_three;   // R13
      req_set[3] = src_evt.grp_four;    // R9 R10
      req_wr     = {wr_req4, wr_req3, wr_req2, wr_req1};
   end

   localparam logic [3:0][7:0] REQ_MASKS = {MASK_FOUR, MASK_THREE, MASK_TWO,
                                            PIFB_MASK_ONE};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_req
         pifb_flag_reg #(
            .IMPL_MASK (REQ_MASKS[g])
         ) u_flag (
            .ref_clk (ref_clk),
            .resetn  (resetn),
            .wr_en   (req_wr[g]),
            .wdata   (reg_req.wdata),
            .hw_set  (req_set[g]),
            .value_r (req_r[g])
         );
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////
   // core interrupt control register

   logic [7:0] core_ctrl_r;    // enables in 7:3, flags in 2:0
   logic [7:0] core_ctrl_nxt;

   // flag bits keep set-wins-over-write like the peripheral flags
   always_comb begin
      core_ctrl_nxt = core_ctrl_r;
      if (wr_core) begin
         core_ctrl_nxt = reg_req.wdata;   // R11
      end
      core_ctrl_nxt[PIFB_BIT_TMR0_FLAG] = core_ctrl_nxt[PIFB_BIT_TMR0_FLAG] |
                                          src_evt.core[2];   // R2 R16
      core_ctrl_nxt[PIFB_BIT_EXT_FLAG]  = core_ctrl_nxt[PIFB_BIT_EXT_FLAG] |
                                          src_evt.core[1];   // R2 R16
      core_ctrl_nxt[PIFB_BIT_CHG_FLAG]  = core_ctrl_nxt[PIFB_BIT_CHG_FLAG] |
                                          src_evt.core[0];   // R2 R16
   end

   // reset clears all enables and flags
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         core_ctrl_r <= PIFB_RST_VAL;   // R5
      end else begin
         core_ctrl_r <= core_ctrl_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // request generation

   logic       periph_any;   // any peripheral flag with its enable
   logic       core_any;     // any core-level source with its enable
   logic       global_en;    // global enable bit
   logic       master_en;    // peripheral master enable bit

   // enables are read only at the combine stage, so flags still latch
   always_comb begin
      global_en  = core_ctrl_r[PIFB_BIT_GLOBAL_EN];
      master_en  = core_ctrl_r[PIFB_BIT_PERIPH_EN];
      periph_any = |(req_r[0] & en_one_r) | |(req_r[1] & en_two_r) |
                   |(req_r[2] & en_three_r) | |(req_r[3] & en_four_r);
      core_any   = (core_ctrl_r[PIFB_BIT_TMR0_FLAG] & core_ctrl_r[PIFB_BIT_TMR0_EN]) |
                   (core_ctrl_r[PIFB_BIT_EXT_FLAG] & core_ctrl_r[PIFB_BIT_EXT_EN]) |
                   (core_ctrl_r[PIFB_BIT_CHG_FLAG] & core_ctrl_r[PIFB_BIT_CHG_EN]);
   end

   // combinational so the core sees a request in the cycle it arises
   assign periph_irq = periph_any & master_en & global_en;   // R1 R15
   assign core_irq   = periph_irq | (core_any & global_en);

   //////////////////////////////////////////////////////////////////////////
   // bank status and mask

   logic [1:0] stat_r;        // sticky bank events
   logic [1:0] mask_r;        // bank interrupt mask
   logic       periph_d_r;    // last periph_irq, for edge detect
   logic       core_d_r;      // last core_irq, for edge detect
   logic [1:0] stat_evt;      // rising-edge events

   // rising edges of the two request lines
   always_comb begin
      stat_evt = '0;
      stat_evt[PIFB_STAT_REQ_RISE]  = periph_irq & ~periph_d_r;
      stat_evt[PIFB_STAT_CORE_RISE] = core_irq & ~core_d_r;
   end

   // edge history
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         periph_d_r <= 1'b0;
         core_d_r   <= 1'b0;
      end else begin
         periph_d_r <= periph_irq;
         core_d_r   <= core_irq;
      end
   end

   // write one to clear; a same-cycle event keeps its bit set
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stat_r <= 2'h0;
      end else begin
         stat_r <= (wr_stat ? (stat_r & ~reg_req.wdata[1:0]) : stat_r) | stat_evt;
      end
   end

   // mask register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mask_r <= 2'h0;
      end else if (wr_mask) begin
         mask_r <= reg_req.wdata[1:0];
      end
   end

   assign bank_irq = |(stat_r & mask_r);

   //////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after the strobe, zero elsewhere

   logic [7:0] rd_mux;   // selected register

   // unmapped indices read as zero
   always_comb begin
      unique case (reg_req.addr)
         PIFB_OFS_CORE_CTRL: rd_mux = core_ctrl_r;   // R11
         PIFB_OFS_EN_ONE:    rd_mux = en_one_r;
         PIFB_OFS_EN_TWO:    rd_mux = en_two_r;
         PIFB_OFS_EN_THREE:  rd_mux = en_three_r;
         PIFB_OFS_EN_FOUR:   rd_mux = en_four_r;
         PIFB_OFS_REQ_ONE:   rd_mux = req_r[0];
         PIFB_OFS_REQ_TWO:   rd_mux = req_r[1];   // R8
         PIFB_OFS_REQ_THREE: rd_mux = req_r[2];
         PIFB_OFS_REQ_FOUR:  rd_mux = req_r[3];
         PIFB_OFS_IRQ_STAT:  rd_mux = {6'h00, stat_r};
         PIFB_OFS_IRQ_MASK:  rd_mux = {6'h00, mask_r};
         default:            rd_mux = 8'h00;   // R6
      endcase
   end

   // registered read data, zero when no read was made
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_req.rd ? rd_mux : 8'h00;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks

   a_master_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
      !core_ctrl_r[PIFB_BIT_PERIPH_EN] |-> !periph_irq)   // R1
      else $error("peripheral request without master enable");

   a_req_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
      (periph_irq == (global_en && master_en &&
       ((req_r[1] & en_two_r) != 8'h00 || (req_r[0] & en_one_r) != 8'h00 ||
        (req_r[2] & en_three_r) != 8'h00 || (req_r[3] & en_four_r) != 8'h00))))  // R15
      else $error("peripheral request mismatch");

   a_flag_no_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
      src_evt.grp_one[0] |=> req_r[0][0])   // R2
      else $error("flag not set by event");

   a_coll_two_set: assert property (@(posedge ref_clk) disable iff (!resetn)
      (LARGE_VARIANT && src_evt.grp_four[1]) |=> req_r[3][1])   // R9
      else $error("serial two collision lost");

   sequence s_event_zero;
      src_evt.grp_four[0] && LARGE_VARIANT;
   endsequence
   sequence s_held_quiet;
      !wr_req4 [*2];
   endsequence
   a_evt_two_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_event_zero ##1 s_held_quiet |-> req_r[3][0])   // R10
      else $error("serial two event flag not held");

   a_en2_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      (en_two_r[2:1] == 2'b00) && (en_three_r[7:6] == 2'b00))   // R6
      else $error("unimplemented enable bit set");

   a_small_gone: assert property (@(posedge ref_clk) disable iff (!resetn)
      !LARGE_VARIANT |-> (en_three_r == 8'h00 && req_r[3] == 8'h00))   // R14
      else $error("large-variant register present");

   a_rd_latency: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_req.rd && reg_req.addr == PIFB_OFS_EN_TWO && !wr_en2)
      |=> reg_rdata == $past(en_two_r))   // R4
      else $error("read data wrong");

   a_core_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr_core && !reg_req.wdata[PIFB_BIT_EXT_FLAG] && !src_evt.core[1])
      |=> !core_ctrl_r[PIFB_BIT_EXT_FLAG])   // R11
      else $error("core flag not cleared");

   // a write lands in the enable register on the next edge, holes cleared
   a_en_two_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_en2 |=> en_two_r == ($past(reg_req.wdata) & MASK_TWO))   // R4 R5
      else $error("enable group two write lost");

   // same for the third group, whose layout is half holes
   a_en_three_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_en3 |=> en_three_r == ($past(reg_req.wdata) & MASK_THREE))   // R7 R5
      else $error("enable group three write lost");

   // the core request never fires while interrupts are off globally
   a_core_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
      !global_en |-> !core_irq)   // R15
      else $error("core request without global enable");

   // core-level flags latch like peripheral flags, a clear cannot hide them
   a_core_flag_set: assert property (@(posedge ref_clk) disable iff (!resetn)
      src_evt.core[2] |=> core_ctrl_r[PIFB_BIT_TMR0_FLAG])   // R2 R16
      else $error("timer zero flag lost");

   // a rise of the request line is never lost to a same-cycle status clear
   sequence s_req_rise;
      periph_irq && !periph_d_r;
   endsequence
   a_stat_rise_kept: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_req_rise |=> stat_r[PIFB_STAT_REQ_RISE])   // R16
      else $error("request rise lost from status");

endmodule

/* File: rtl/pifb_flag_reg.sv */
`timescale 1ns/1ps
// one 8-bit flag register: hardware sets, software writes, set wins
module pifb_flag_reg #(
   parameter logic [7:0] IMPL_MASK = 8'hFF
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // software side
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   // hardware set strobes
   input  wire logic [7:0] hw_set,
   // stored value
   output logic      [7:0] value_r
);
   import pifb_pkg::*;

   logic [7:0] value_nxt;   // next stored value

   // write first, then hardware sets on top so no event is lost
   always_comb begin
      value_nxt = value_r;
      if (wr_en) begin
         value_nxt = wdata;
      end
      value_nxt = (value_nxt | hw_set) & IMPL_MASK;   // R2 R16 R6
   end

   // reset clears every bit
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         value_r <= PIFB_RST_VAL;   // R5
      end else begin
         value_r <= value_nxt;
      end
   end

   // a set strobe on an implemented bit shows up next cycle
   a_set_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
      (|(hw_set & IMPL_MASK)) |=> ((value_r & $past(hw_set) & IMPL_MASK)
                                   == ($past(hw_set) & IMPL_MASK)))   // R16
      else $error("flag set lost");

   // unimplemented bits never read as one
   a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      (value_r & ~IMPL_MASK) == 8'h00)   // R6
      else $error("unimplemented flag bit set");

endmodule

/* File: rtl/pifb_pkg.sv */
package pifb_pkg;

   // register indices on the plain register port
   localparam logic [3:0] PIFB_OFS_CORE_CTRL = 4'h0;
   localparam logic [3:0] PIFB_OFS_EN_ONE    = 4'h1;
   localparam logic [3:0] PIFB_OFS_EN_TWO    = 4'h2;
   localparam logic [3:0] PIFB_OFS_EN_THREE  = 4'h3;
   localparam logic [3:0] PIFB_OFS_EN_FOUR   = 4'h4;
   localparam logic [3:0] PIFB_OFS_REQ_ONE   = 4'h5;
   localparam logic [3:0] PIFB_OFS_REQ_TWO   = 4'h6;
   localparam logic [3:0] PIFB_OFS_REQ_THREE = 4'h7;
   localparam logic [3:0] PIFB_OFS_REQ_FOUR  = 4'h8;
   localparam logic [3:0] PIFB_OFS_IRQ_STAT  = 4'h9;
   localparam logic [3:0] PIFB_OFS_IRQ_MASK  = 4'hA;

   // value after every reset
   localparam logic [7:0] PIFB_RST_VAL = 8'h00;

   // implemented bit masks per group (small variant / large variant)
   localparam logic [7:0] PIFB_MASK_ONE       = 8'hFF;
   localparam logic [7:0] PIFB_MASK_TWO_SMALL = 8'hF8;
   localparam logic [7:0] PIFB_MASK_TWO_LARGE = 8'hF9;
   localparam logic [7:0] PIFB_MASK_THREE     = 8'h3A;
   localparam logic [7:0] PIFB_MASK_FOUR      = 8'h03;

   // core control field positions
   localparam int PIFB_BIT_GLOBAL_EN  = 7;
   localparam int PIFB_BIT_PERIPH_EN  = 6;
   localparam int PIFB_BIT_TMR0_EN    = 5;
   localparam int PIFB_BIT_EXT_EN     = 4;
   localparam int PIFB_BIT_CHG_EN     = 3;
   localparam int PIFB_BIT_TMR0_FLAG  = 2;
   localparam int PIFB_BIT_EXT_FLAG   = 1;
   localparam int PIFB_BIT_CHG_FLAG   = 0;

   // bank-level status bits
   localparam int PIFB_STAT_REQ_RISE  = 0;
   localparam int PIFB_STAT_CORE_RISE = 1;

   // event strobes from the sources, one per flag position
   typedef struct packed {
      logic [7:0] grp_one;
      logic [7:0] grp_two;
      logic [7:0] grp_three;
      logic [7:0] grp_four;
      logic [2:0] core;
   } pifb_events_t;

   // plain register port
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pifb_req_t;

endpackage
